// >>> rtl/ccgc_pkg.sv
// Constants, register layout and state codes for the CC port general control block.
package ccgc_pkg;
    // Register offsets and reset value.
    localparam logic [7:0] CCGC_GEN_CTRL_OFS = 8'h0A;
    localparam logic [7:0] CCGC_REV_OFS      = 8'hA0;
    localparam logic [7:0] CCGC_GEN_CTRL_RST = 8'h00;
    // Serial bus addresses selected by the address strap.
    localparam logic [6:0] CCGC_ADDR_STRAP_LO = 7'h47;
    localparam logic [6:0] CCGC_ADDR_STRAP_HI = 7'h67;
    // Clock rate in kHz and cc_settle_time_sel periods in milliseconds.
    localparam int CCGC_CLK_KHZ   = 25000;
    localparam int CCGC_DEB_MS_00 = 168;
    localparam int CCGC_DEB_MS_01 = 118;
    localparam int CCGC_DEB_MS_10 = 134;
    localparam int CCGC_DEB_MS_11 = 152;
    localparam int CCGC_DEB_W     = 23;
    // Byte framing.
    localparam logic [3:0] CCGC_BITS_PER_BYTE = 4'h8;

    typedef enum logic [1:0] {
        CCGC_ROLE_DRP  = 2'h0,
        CCGC_ROLE_UFP  = 2'h1,
        CCGC_ROLE_DFP  = 2'h2,
        CCGC_ROLE_DRP2 = 2'h3
    } ccgc_role_t;

    typedef enum logic [1:0] {
        CCGC_TRY_NONE = 2'h0,
        CCGC_TRY_SNK  = 2'h1,
        CCGC_TRY_RSVD = 2'h2,
        CCGC_TRY_SRC  = 2'h3
    } ccgc_try_t;

    // General control register layout, bit 7 first.
    typedef struct packed {
        logic [1:0] settle_sel;
        ccgc_role_t role;
        logic       soft_rst;
        ccgc_try_t  try_pol;
        logic       term_dis;
    } ccgc_gen_ctrl_t;

    typedef enum logic [4:0] {
        CCGC_ST_IDLE = 5'h01,
        CCGC_ST_ADDR = 5'h02,
        CCGC_ST_REG  = 5'h04,
        CCGC_ST_WR   = 5'h08,
        CCGC_ST_RD   = 5'h10
    } ccgc_state_t;
endpackage

// >>> rtl/ccgc_top.sv
// General control and revision registers of a Type-C CC controller behind a serial slave port.

// How it works
// - The two-bit settle select picks a CC cc_settle_time_sel of 168, 118, 134 or 152 ms, 168 after reset.
// - The two-bit role field picks DRP (00 or 11), UFP (01) or DFP (10), resetting to DRP.
// - Writing 1 to bit 3 starts a soft reset of the logic and the bit clears by itself.
// - A soft reset may reinitialise the connection status fields, so the host rereads them.
// - As DRP the port follows the try policy: standard, Try.SNK, reserved or Try.SRC.
// - Setting bit 0 removes the CC terminations and forces the CC machine into disabled.
// - While bit 0 is 1 the CC machine stays disabled; at 0 terminations follow the role.
// - General control sits at 0x0A, resets to 0x00, all fields writable but bit 3 set-only.
// - A read-only eight-bit revision sits at 0xA0 and ignores writes.
// - With the strap low the port answers at bus address 0x47.
// - DFP is left on a role change, on a soft reset, or on a falling chip enable.
// - Any connection status change sets a sticky flag and pulls the alert low until cleared.
module ccgc_top #(
    parameter logic [7:0] REVISION = 8'h5A, // Arbitrary value.
    parameter int DEB_CYC_00 = ccgc_pkg::CCGC_DEB_MS_00 * ccgc_pkg::CCGC_CLK_KHZ,
    parameter int DEB_CYC_01 = ccgc_pkg::CCGC_DEB_MS_01 * ccgc_pkg::CCGC_CLK_KHZ,
    parameter int DEB_CYC_10 = ccgc_pkg::CCGC_DEB_MS_10 * ccgc_pkg::CCGC_CLK_KHZ,
    parameter int DEB_CYC_11 = ccgc_pkg::CCGC_DEB_MS_11 * ccgc_pkg::CCGC_CLK_KHZ
) (
    // Clock and reset.
    input  wire logic            ref_clk_i,
    input  wire logic            arst_n_i,
    // Serial slave pins.
    input  wire logic            scl_i,
    input  wire logic            sda_i,
    output logic                 sda_o,
    output logic                 sda_oe_n_o,
    input  wire logic            addr_strap_i,
    // Chip pins and status events.
    input  wire logic            en_n_i,
    input  wire logic            csr_change_i,
    input  wire logic            int_clr_i,
    output logic                 alert_n_o,
    // CC sensing.
    input  wire logic [1:0]      cc_i,
    output logic [1:0]           cc_deb_o,
    output logic                 cc_stable_o,
    // Control to the CC state machine.
    output ccgc_pkg::ccgc_role_t role_o,
    output logic                 try_snk_o,
    output logic                 try_src_o,
    output logic                 term_en_o,
    output logic                 cc_sm_hold_o,
    output logic                 soft_rst_o,
    output logic                 dfp_exit_o
);
    // Serial slave and register state.
    ccgc_pkg::ccgc_state_t    st_r, st_nxt;
    ccgc_pkg::ccgc_gen_ctrl_t gc_r, gc_nxt;
    logic [7:0] sh_r, sh_nxt, ptr_r, ptr_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic       ackph_r, ackph_nxt, oe_n_r, oe_n_nxt, scl_q_r, sda_q_r;
    logic [6:0] addr_r, addr_nxt;
    logic       settle_wr, role_wr;
    logic       scl_rise, scl_fall, start_c, stop_c;
    logic [7:0] rdata;

    assign scl_rise = scl_i & ~scl_q_r;
    assign scl_fall = ~scl_i & scl_q_r;
    assign start_c  = scl_i & scl_q_r & sda_q_r & ~sda_i;
    assign stop_c   = scl_i & scl_q_r & ~sda_q_r & sda_i;

    always_comb begin
        case (ptr_r)
            ccgc_pkg::CCGC_GEN_CTRL_OFS: rdata = gc_r;
            ccgc_pkg::CCGC_REV_OFS:      rdata = REVISION;
            default:                     rdata = 8'h00;
        endcase
    end

    always_comb begin
        st_nxt    = st_r;
        sh_nxt    = sh_r;
        ptr_nxt   = ptr_r;
        cnt_nxt   = cnt_r;
        ackph_nxt = ackph_r;
        oe_n_nxt  = oe_n_r;
        settle_wr = 1'b0;
        role_wr   = 1'b0;
        // Strap follows the pin after reset release.
        addr_nxt  = addr_strap_i ? ccgc_pkg::CCGC_ADDR_STRAP_HI : ccgc_pkg::CCGC_ADDR_STRAP_LO;
        gc_nxt    = gc_r;
        gc_nxt.soft_rst = 1'b0;
        if (start_c) begin
            st_nxt    = ccgc_pkg::CCGC_ST_ADDR;
            cnt_nxt   = 4'h0;
            ackph_nxt = 1'b0;
            oe_n_nxt  = 1'b1;
        end else if (stop_c) begin
            st_nxt   = ccgc_pkg::CCGC_ST_IDLE;
            oe_n_nxt = 1'b1;
        end else if (st_r != ccgc_pkg::CCGC_ST_IDLE) begin
            if (scl_rise) begin
                if (cnt_r < ccgc_pkg::CCGC_BITS_PER_BYTE) begin
                    sh_nxt  = {sh_r[6:0], sda_i};
                    cnt_nxt = cnt_r + 4'h1;
                end else if (st_r == ccgc_pkg::CCGC_ST_RD && sda_i) begin
                    st_nxt = ccgc_pkg::CCGC_ST_IDLE;
                end
            end else if (scl_fall) begin
                if (ackph_r) begin
                    ackph_nxt = 1'b0;
                    cnt_nxt   = 4'h0;
                    oe_n_nxt  = 1'b1;
                    if (st_r == ccgc_pkg::CCGC_ST_RD) begin
                        sh_nxt   = rdata;
                        oe_n_nxt = rdata[7];
                    end
                end else if (cnt_r < ccgc_pkg::CCGC_BITS_PER_BYTE) begin
                    if (st_r == ccgc_pkg::CCGC_ST_RD) begin
                        oe_n_nxt = sh_r[7];
                    end
                end else begin
                    ackph_nxt = 1'b1;
                    oe_n_nxt  = 1'b0;
                    case (st_r)
                        ccgc_pkg::CCGC_ST_ADDR: begin
                            if (sh_r[7:1] == addr_r) begin
                                st_nxt = sh_r[0] ? ccgc_pkg::CCGC_ST_RD : ccgc_pkg::CCGC_ST_REG;
                            end else begin
                                st_nxt   = ccgc_pkg::CCGC_ST_IDLE;
                                oe_n_nxt = 1'b1;
                            end
                        end
                        ccgc_pkg::CCGC_ST_REG: begin
                            ptr_nxt = sh_r;
                            st_nxt  = ccgc_pkg::CCGC_ST_WR;
                        end
                        ccgc_pkg::CCGC_ST_WR: begin
                            if (ptr_r == ccgc_pkg::CCGC_GEN_CTRL_OFS) begin
                                gc_nxt    = sh_r;
                                settle_wr = 1'b1;
                                role_wr   = (sh_r[5:4] != gc_r.role);
                            end
                        end
                        ccgc_pkg::CCGC_ST_RD: oe_n_nxt = 1'b1;
                        default: st_nxt = ccgc_pkg::CCGC_ST_IDLE;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_r    <= ccgc_pkg::CCGC_ST_IDLE;
            gc_r    <= ccgc_pkg::CCGC_GEN_CTRL_RST;
            sh_r    <= 8'h00;
            ptr_r   <= 8'h00;
            cnt_r   <= 4'h0;
            ackph_r <= 1'b0;
            oe_n_r  <= 1'b1;
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
            addr_r  <= ccgc_pkg::CCGC_ADDR_STRAP_LO;
        end else begin
            st_r    <= st_nxt;
            gc_r    <= gc_nxt;
            sh_r    <= sh_nxt;
            ptr_r   <= ptr_nxt;
            cnt_r   <= cnt_nxt;
            ackph_r <= ackph_nxt;
            oe_n_r  <= oe_n_nxt;
            scl_q_r <= scl_i;
            sda_q_r <= sda_i;
            addr_r  <= addr_nxt;
        end
    end

    assign sda_o      = 1'b0;
    assign sda_oe_n_o = oe_n_r;

    // Role decode. Both 00 and 11 decode as DRP.
    logic drp;
    assign drp          = (gc_r.role == ccgc_pkg::CCGC_ROLE_DRP) ||
                          (gc_r.role == ccgc_pkg::CCGC_ROLE_DRP2);
    assign role_o       = gc_r.role;
    assign try_snk_o    = drp && gc_r.try_pol == ccgc_pkg::CCGC_TRY_SNK;
    assign try_src_o    = drp && gc_r.try_pol == ccgc_pkg::CCGC_TRY_SRC;
    assign term_en_o    = ~gc_r.term_dis;
    assign cc_sm_hold_o = gc_r.term_dis;
    assign soft_rst_o   = gc_r.soft_rst;

    // Cc_settle_time_sel of the CC levels.
    logic [ccgc_pkg::CCGC_DEB_W-1:0] deb_cnt_r, deb_cnt_nxt;
    logic [1:0] cc_prev_r, cc_prev_nxt, cc_deb_r, cc_deb_nxt;
    logic       stable_r, stable_nxt, settle_wr_r;

    function automatic logic [ccgc_pkg::CCGC_DEB_W-1:0] deb_load(input logic [1:0] sel);
        case (sel)
            2'h0:    deb_load = DEB_CYC_00[ccgc_pkg::CCGC_DEB_W-1:0];
            2'h1:    deb_load = DEB_CYC_01[ccgc_pkg::CCGC_DEB_W-1:0];
            2'h2:    deb_load = DEB_CYC_10[ccgc_pkg::CCGC_DEB_W-1:0];
            default: deb_load = DEB_CYC_11[ccgc_pkg::CCGC_DEB_W-1:0];
        endcase
    endfunction

    always_comb begin
        cc_prev_nxt = cc_i;
        cc_deb_nxt  = cc_deb_r;
        stable_nxt  = stable_r;
        deb_cnt_nxt = deb_cnt_r;
        if (cc_i != cc_prev_r || settle_wr_r || gc_r.soft_rst) begin
            deb_cnt_nxt = deb_load(gc_r.settle_sel);
            stable_nxt  = 1'b0;
        end else if (deb_cnt_r != '0) begin
            deb_cnt_nxt = deb_cnt_r - 1'b1;
        end else begin
            stable_nxt = 1'b1;
            cc_deb_nxt = cc_prev_r;
        end
    end

    // Event flags: alert, DFP exit and enable edge.
    logic int_r, int_nxt, dfp_exit_r, dfp_exit_nxt, en_n_q_r;

    always_comb begin
        int_nxt      = csr_change_i | (int_r & ~int_clr_i);
        dfp_exit_nxt = gc_r.role == ccgc_pkg::CCGC_ROLE_DFP &&
                       (role_wr || gc_nxt.soft_rst || (en_n_q_r && !en_n_i));
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            deb_cnt_r   <= DEB_CYC_00[ccgc_pkg::CCGC_DEB_W-1:0];
            cc_prev_r   <= 2'h0;
            cc_deb_r    <= 2'h0;
            stable_r    <= 1'b0;
            settle_wr_r <= 1'b0;
            int_r       <= 1'b0;
            dfp_exit_r  <= 1'b0;
            en_n_q_r    <= 1'b0;
        end else begin
            deb_cnt_r   <= deb_cnt_nxt;
            cc_prev_r   <= cc_prev_nxt;
            cc_deb_r    <= cc_deb_nxt;
            stable_r    <= stable_nxt;
            settle_wr_r <= settle_wr;
            int_r       <= int_nxt;
            dfp_exit_r  <= dfp_exit_nxt;
            en_n_q_r    <= en_n_i;
        end
    end

    assign cc_deb_o    = cc_deb_r;
    assign cc_stable_o = stable_r;
    assign alert_n_o   = ~int_r;
    assign dfp_exit_o  = dfp_exit_r;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);

    chk_srst_self_clear: assert property (soft_rst_o |=> !soft_rst_o)
        else $error("soft reset bit did not clear");
    chk_term_hold: assert property (gc_r.term_dis |-> cc_sm_hold_o && !term_en_o)
        else $error("state machine not held while terminations disabled");
    chk_try_drp_only: assert property ((try_snk_o || try_src_o) |->
        role_o == ccgc_pkg::CCGC_ROLE_DRP || role_o == ccgc_pkg::CCGC_ROLE_DRP2)
        else $error("try policy active outside DRP");
    chk_try_reserved: assert property (gc_r.try_pol == ccgc_pkg::CCGC_TRY_RSVD
        |-> !try_snk_o && !try_src_o)
        else $error("reserved try code acted");
    chk_dfp_exit_cause: assert property (dfp_exit_o |->
        $past(role_o) == ccgc_pkg::CCGC_ROLE_DFP
        && ($past(role_wr) || soft_rst_o || $past(en_n_q_r && !en_n_i)))
        else $error("DFP exit without cause");
    chk_deb_restart: assert property (cc_i != cc_prev_r |=> !cc_stable_o)
        else $error("cc_settle_time_sel not restarted on CC change");
    chk_deb_count_done: assert property ($rose(cc_stable_o) |-> $past(deb_cnt_r) == '0)
        else $error("CC declared stable before count expired");
    chk_alert_sticky: assert property ((csr_change_i || (!alert_n_o && !int_clr_i))
        |=> !alert_n_o)
        else $error("alert not held after status change");
    chk_nack_other_addr: assert property (st_r == ccgc_pkg::CCGC_ST_ADDR && scl_fall
        && !ackph_r && cnt_r == ccgc_pkg::CCGC_BITS_PER_BYTE && sh_r[7:1] != addr_r
        && !start_c && !stop_c |=> sda_oe_n_o)
        else $error("acknowledged a foreign address");

    cov_soft_reset: cover property (soft_rst_o);
    cov_dfp_exit:   cover property (dfp_exit_o);
    cov_cc_stable:  cover property ($rose(cc_stable_o));
    cov_reg_write:  cover property (settle_wr);
endmodule

// >>> tb/ccgc_host_model.sv
// Serial bus host model that reaches the general control and revision registers.
module ccgc_host_model (
    // Clock.
    input  wire logic ref_clk_i,
    // Bus wires, data as seen on the pulled-up line.
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask

    // Data changes only while the clock is low; the line is read late in the high phase.
    task automatic bit_io(input logic b, output logic r);
        sda_o <= b;
        tick(2);
        scl_o <= 1'b1;
        tick(3);
        r = sda_i;
        scl_o <= 1'b0;
        tick(2);
    endtask

    task automatic start_c();
        sda_o <= 1'b1;
        tick(2);
        scl_o <= 1'b1;
        tick(3);
        sda_o <= 1'b0;
        tick(3);
        scl_o <= 1'b0;
        tick(2);
    endtask

    task automatic stop_c();
        sda_o <= 1'b0;
        tick(2);
        scl_o <= 1'b1;
        tick(3);
        sda_o <= 1'b1;
        tick(3);
    endtask

    // Sends a byte MSB first, returns what the line showed and the acknowledge.
    task automatic byte_io(input logic [7:0] d, output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
            q[i] = r;
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    // Writes one byte at a register offset; ok is set only when all three bytes are acknowledged.
    task automatic wr_reg(input logic [6:0] a, input logic [7:0] ofs, input logic [7:0] dat,
                          output logic ok);
        logic [7:0] q;
        logic       k0;
        logic       k1;
        logic       k2;
        start_c();
        byte_io({a, 1'b0}, q, k0);
        byte_io(ofs, q, k1);
        byte_io(dat, q, k2);
        stop_c();
        ok = k0 & k1 & k2;
    endtask

    // The last data byte is refused by the host, which ends the read.
    task automatic rd_reg(input logic [6:0] a, input logic [7:0] ofs, output logic [7:0] dat);
        logic [7:0] q;
        logic       k;
        start_c();
        byte_io({a, 1'b0}, q, k);
        byte_io(ofs, q, k);
        start_c();
        byte_io({a, 1'b1}, q, k);
        byte_io(8'hFF, dat, k);
        stop_c();
    endtask
endmodule

// >>> tb/ccgc_top_tb.sv
// Self-checking bench for the general control and revision registers.
module ccgc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0] REV = 8'hC3; // Arbitrary value.
    localparam int DEB [4] = '{20, 40, 60, 80};

    logic                 clk, arst_n, scl, sda_m, strap, en_n, csr_chg, int_clr, ok;
    logic                 sda_d, sda_oe_n, alert_n, cc_stable, try_snk, try_src;
    logic                 term_en, hold, srst, dfp_exit;
    logic [1:0]           cc, cc_deb;
    logic [7:0]           rd;
    ccgc_pkg::ccgc_role_t role;
    int                   err_total, n_tests, srst_cnt, dfp_cnt, d0, s0, n;
    wire                  sda_w = sda_m & (sda_oe_n | sda_d);

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    ccgc_top #(.REVISION(REV), .DEB_CYC_00(DEB[0]), .DEB_CYC_01(DEB[1]),
               .DEB_CYC_10(DEB[2]), .DEB_CYC_11(DEB[3])) dut (
        .ref_clk_i(clk), .arst_n_i(arst_n), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_d),
        .sda_oe_n_o(sda_oe_n), .addr_strap_i(strap), .en_n_i(en_n), .csr_change_i(csr_chg),
        .int_clr_i(int_clr), .alert_n_o(alert_n), .cc_i(cc), .cc_deb_o(cc_deb),
        .cc_stable_o(cc_stable), .role_o(role), .try_snk_o(try_snk), .try_src_o(try_src),
        .term_en_o(term_en), .cc_sm_hold_o(hold), .soft_rst_o(srst), .dfp_exit_o(dfp_exit));

    ccgc_host_model host (.ref_clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_o(sda_m));

    // Pulse counters for the one-cycle outputs.
    always @(posedge clk) begin
        if (!arst_n) begin
            srst_cnt <= 0;
            dfp_cnt  <= 0;
        end else begin
            srst_cnt <= srst_cnt + int'(srst);
            dfp_cnt  <= dfp_cnt + int'(dfp_exit);
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
        host.wr_reg(7'h47, ofs, d, ok);
        check({7'h00, ok}, 8'h01);
    endtask

    task automatic rdc(input logic [7:0] ofs, input logic [7:0] exp);
        host.rd_reg(7'h47, ofs, rd);
        check(rd, exp);
    endtask

    initial begin
        err_total = 0;
        n_tests = 0;
        arst_n = 1'b0;
        strap = 1'b0; // Strap low selects bus address 0x47.
        en_n = 1'b0;
        csr_chg = 1'b0;
        int_clr = 1'b0;
        cc = 2'h0;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        check({2'b00, role, term_en, hold, alert_n, srst}, 8'h0A);
        rdc(8'h0A, 8'h00);
        rdc(8'hA0, REV);
        wr(8'hA0, 8'hFF);
        rdc(8'hA0, REV);
        rdc(8'h3C, 8'h00);
        $display("test reset and read-only done");
        d0 = dfp_cnt;
        for (int r = 0; r < 4; r++) begin
            for (int p = 0; p < 4; p++) begin
                wr(8'h0A, {2'b00, r[1:0], 1'b0, p[1:0], 1'b0});
                check({4'h0, role, try_snk, try_src}, {4'h0, r[1:0], (r == 0 || r == 3) && p == 1,
                      (r == 0 || r == 3) && p == 3});
                rdc(8'h0A, {2'b00, r[1:0], 1'b0, p[1:0], 1'b0});
            end
        end
        check(8'(dfp_cnt - d0), 8'h01);
        $display("test role and try policy done");
        wr(8'h0A, 8'h01);
        check({6'h00, term_en, hold}, 8'h01);
        wr(8'h0A, 8'h00);
        check({6'h00, term_en, hold}, 8'h02);
        $display("test termination done");
        wr(8'h0A, 8'h20);
        d0 = dfp_cnt;
        s0 = srst_cnt;
        wr(8'h0A, 8'h28);
        check(8'(srst_cnt - s0), 8'h01);
        check(8'(dfp_cnt - d0), 8'h01);
        rdc(8'h0A, 8'h20);
        @(posedge clk) en_n <= 1'b1;
        repeat (3) @(posedge clk);
        en_n <= 1'b0;
        repeat (3) @(posedge clk);
        check(8'(dfp_cnt - d0), 8'h02);
        wr(8'h0A, 8'h10);
        check(8'(dfp_cnt - d0), 8'h03);
        $display("test soft reset and dfp exit done");
        host.wr_reg(7'h67, 8'h0A, 8'h30, ok);
        check({7'h00, ok}, 8'h00);
        rdc(8'h0A, 8'h10);
        @(posedge clk) strap <= 1'b1;
        repeat (4) @(posedge clk);
        host.wr_reg(7'h67, 8'h0A, 8'h00, ok);
        check({7'h00, ok}, 8'h01);
        strap <= 1'b0;
        repeat (4) @(posedge clk);
        rdc(8'h0A, 8'h00);
        $display("test bus address done");
        @(posedge clk) csr_chg <= 1'b1;
        @(posedge clk) csr_chg <= 1'b0;
        repeat (5) @(posedge clk);
        #1 check({7'h00, alert_n}, 8'h00);
        @(posedge clk) int_clr <= 1'b1;
        @(posedge clk) int_clr <= 1'b0;
        repeat (3) @(posedge clk);
        #1 check({7'h00, alert_n}, 8'h01);
        $display("test alert done");
        for (int k = 0; k < 4; k++) begin
            wr(8'h0A, {k[1:0], 6'h00});
            @(posedge clk) cc <= cc + 2'h1;
            repeat (3) @(posedge clk);
            #1 check({7'h00, cc_stable}, 8'h00);
            n = 3;
            while (cc_stable !== 1'b1 && n < 200) begin
                @(posedge clk);
                #1 n++;
            end
            if (n >= 200) begin
                err_total++;
                stop_test();
            end
            check(8'(n >= DEB[k] && n <= DEB[k] + 4), 8'h01);
            check({6'h00, cc_deb}, {6'h00, cc});
        end
        $display("test cc_settle_time_sel done");
        stop_test();
    end
endmodule
